/* console_serial_pkg.sv */
// Constants and types shared by the console serial line unit
package console_serial_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int unsigned CLOCK_HZ = 100_000_000;
	localparam int unsigned LOOP_BAUD = 19200;
	localparam int unsigned LOOP_BIT_CYCLES = CLOCK_HZ / LOOP_BAUD;
	localparam int unsigned DEFAULT_BAUD = 9600;
	localparam int unsigned DEFAULT_BIT_CYCLES = CLOCK_HZ / DEFAULT_BAUD;

	// ------------------------------------------------------------
	// Register byte addresses
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_RX_CONTROL_STATUS = 8'h00;
	localparam logic [7:0] ADDR_RX_DATA_BUFFER = 8'h04;
	localparam logic [7:0] ADDR_TX_CONTROL_STATUS = 8'h08;
	localparam logic [7:0] ADDR_TX_DATA_BUFFER = 8'h0C;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
	localparam logic [7:0] ADDR_LINE_CONFIG = 8'h18;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int RX_CS_AVAIL_BIT = 7;
	localparam int RX_CS_IE_BIT = 6;
	localparam int RX_BUF_ERROR_BIT = 15;
	localparam int RX_BUF_OVERRUN_BIT = 14;
	localparam int RX_BUF_FRAMING_BIT = 13;
	localparam int RX_BUF_PARITY_BIT = 12;
	localparam int TX_CS_READY_BIT = 7;
	localparam int TX_CS_IE_BIT = 6;
	localparam int TX_CS_MAINT_BIT = 2;
	localparam int IRQ_RX_BIT = 0;
	localparam int IRQ_TX_BIT = 1;
	localparam int IRQ_ERR_BIT = 2;
	localparam int CFG_PARITY_EN_BIT = 16;
	localparam int CFG_PARITY_ODD_BIT = 17;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic RX_IE_RESET = 1'b0;
	localparam logic TX_IE_RESET = 1'b0;
	localparam logic TX_READY_RESET = 1'b1;
	localparam logic MAINT_RESET = 1'b0;
	localparam logic [2:0] IRQ_STATUS_RESET = 3'h0;
	localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
	localparam logic PARITY_EN_RESET = 1'b0;
	localparam logic PARITY_ODD_RESET = 1'b0;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef struct packed
	{
		logic [15:0] bit_cycles;
		logic parity_en;
		logic parity_odd;
	} line_cfg_t;

	typedef struct packed
	{
		logic [7:0] data;
		logic framing_bad;
		logic parity_bad;
	} rx_char_t;

endpackage

/* console_serial_rx.sv */
// Serial character receiver of the console serial line unit
`timescale 1ns/1ps
module console_serial_rx
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic line_in,
	input wire console_serial_pkg::line_cfg_t cfg,
	output logic char_valid,
	output console_serial_pkg::rx_char_t rx_char
);
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rx_state_t;

	rx_state_t state_r;
	logic [15:0] count_r;
	logic [2:0] bit_r;
	logic [7:0] shift_r;
	logic parity_r;
	logic parity_bad_r;
	logic line_prev_r;
	logic char_valid_r;
	console_serial_pkg::rx_char_t rx_char_r;

	wire tick = (count_r == 16'h0000);
	wire [15:0] reload = cfg.bit_cycles - 16'h0001;

	assign char_valid = char_valid_r;
	assign rx_char = rx_char_r;

	// ------------------------------------------------------------
	// Frame sampling at mid bit
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_r <= RX_IDLE;
			count_r <= 16'h0000;
			bit_r <= 3'h0;
			shift_r <= 8'h00;
			parity_r <= 1'b0;
			parity_bad_r <= 1'b0;
			line_prev_r <= 1'b1;
			char_valid_r <= 1'b0;
			rx_char_r <= '0;
		end
		else
		begin
			line_prev_r <= line_in;
			char_valid_r <= 1'b0;
			if (!tick)
				count_r <= count_r - 16'h0001;
			case (state_r)
				RX_IDLE:
					if (line_prev_r && !line_in)
					begin
						state_r <= RX_START;
						count_r <= {1'b0, cfg.bit_cycles[15:1]};
					end
				RX_START:
					if (tick)
					begin
						state_r <= line_in ? RX_IDLE : RX_DATA;
						count_r <= reload;
						bit_r <= 3'h0;
						parity_r <= cfg.parity_odd;
						parity_bad_r <= 1'b0;
					end
				RX_DATA:
					if (tick)
					begin
						shift_r <= {line_in, shift_r[7:1]};
						parity_r <= parity_r ^ line_in;
						count_r <= reload;
						bit_r <= bit_r + 3'h1;
						if (bit_r == 3'h7)
							state_r <= cfg.parity_en ? RX_PARITY : RX_STOP;
					end
				RX_PARITY:
					if (tick)
					begin
						parity_bad_r <= (line_in != parity_r);
						count_r <= reload;
						state_r <= RX_STOP;
					end
				RX_STOP:
					if (tick)
					begin
						char_valid_r <= 1'b1;
						rx_char_r.data <= shift_r;
						rx_char_r.framing_bad <= !line_in;
						rx_char_r.parity_bad <= parity_bad_r;
						state_r <= RX_IDLE;
					end
				default:
					state_r <= RX_IDLE;
			endcase
		end
	end
endmodule

/* console_serial_line_unit.sv */
// Console serial line unit: APB registers, transmitter, loopback, interrupts
//
// Contract
// - Receive-complete flag sets once a full character sits in the receive buffer.
// - Receive-complete clears on a receive buffer access, unless a character loaded in its setup cycle, and on reset.
// - Receive interrupt enable is read/write; with it set, completion requests interrupt.
// - Receive buffer bit 15 reads as OR of overrun, framing and parity flags.
// - Overrun sets when a character arrives unread; clears on a receive buffer access, under the same rule as receive-complete, or on reset.
// - Framing flag sets on a missing stop bit; clears on a good frame.
// - Parity flag sets on wrong parity; clears when a later character passes.
// - Receive buffer low byte presents the received character, read only.
// - Transmit-ready sets when the buffer can take a character; clears on write.
// - Transmit ready with its enable set raises a transmit interrupt request.
// - Transmit interrupt enable is read/write; cleared by software or reset.
// - Maintenance bit loops the transmit serial output into the receiver.
// - In maintenance loopback the line runs at a fixed 19200 baud.
// - Maintenance bit is read/write; cleared by reset or writing zero.
// - Software writes the character to send into the transmit buffer low byte.
`timescale 1ns/1ps
module console_serial_line_unit
#(
	parameter int unsigned LOOP_BIT_CYCLES = console_serial_pkg::LOOP_BIT_CYCLES,
	parameter int unsigned DEFAULT_BIT_CYCLES = console_serial_pkg::DEFAULT_BIT_CYCLES
)
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic serial_in,
	output logic serial_out,
	output logic irq
);
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} tx_state_t;

	localparam logic [15:0] LOOP_CYCLES_16 = LOOP_BIT_CYCLES[15:0];
	localparam logic [15:0] DEFAULT_CYCLES_16 = DEFAULT_BIT_CYCLES[15:0];

	// ------------------------------------------------------------
	// Address decoding
	// ------------------------------------------------------------
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] reg_addr);
		hit = (addr == reg_addr);
	endfunction

	wire setup = psel && !penable;
	wire access = psel && penable;
	wire sel_rx_cs = hit(paddr, console_serial_pkg::ADDR_RX_CONTROL_STATUS);
	wire sel_rx_buf = hit(paddr, console_serial_pkg::ADDR_RX_DATA_BUFFER);
	wire sel_tx_cs = hit(paddr, console_serial_pkg::ADDR_TX_CONTROL_STATUS);
	wire sel_tx_buf = hit(paddr, console_serial_pkg::ADDR_TX_DATA_BUFFER);
	wire sel_irq_status = hit(paddr, console_serial_pkg::ADDR_IRQ_STATUS);
	wire sel_irq_mask = hit(paddr, console_serial_pkg::ADDR_IRQ_MASK);
	wire sel_cfg = hit(paddr, console_serial_pkg::ADDR_LINE_CONFIG);
	wire mapped = sel_rx_cs | sel_rx_buf | sel_tx_cs | sel_tx_buf | sel_irq_status
		| sel_irq_mask | sel_cfg;
	wire wr = access && pwrite && mapped;
	wire wr_lane0 = wr && pstrb[0];
	wire wr_lane1 = wr && pstrb[1];
	wire wr_lane2 = wr && pstrb[2];
	wire rx_buf_access = access && sel_rx_buf;
	wire irq_status_read = access && !pwrite && sel_irq_status;

	assign pready = 1'b1;
	assign pslverr = access && !mapped;

	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	logic rx_avail_r;
	logic rx_ie_r;
	logic overrun_r;
	logic [7:0] rx_data_r;
	logic framing_r;
	logic parity_flag_r;
	logic tx_ready_r;
	logic tx_ie_r;
	logic maint_r;
	logic [7:0] tx_hold_r;
	logic [2:0] irq_status_r;
	logic [2:0] irq_mask_r;
	logic [2:0] irq_snap_r;
	logic rx_load_in_setup_r;
	logic rx_req_prev_r;
	logic tx_req_prev_r;
	logic err_prev_r;
	logic [31:0] prdata_r;
	console_serial_pkg::line_cfg_t cfg_r;
	console_serial_pkg::line_cfg_t line_cfg;

	// ------------------------------------------------------------
	// Receive path with loopback selection
	// ------------------------------------------------------------
	logic rx_sync1_r;
	logic rx_sync2_r;
	logic tx_line_r;
	logic pin_out_r;
	logic rx_valid;
	console_serial_pkg::rx_char_t rx_char;

	wire rx_line = maint_r ? tx_line_r : rx_sync2_r;

	always_comb
	begin
		line_cfg = cfg_r;
		if (maint_r)
			line_cfg.bit_cycles = LOOP_CYCLES_16;
	end

	console_serial_rx rx_unit
	(
		.clock(clock),
		.reset_n(reset_n),
		.line_in(rx_line),
		.cfg(line_cfg),
		.char_valid(rx_valid),
		.rx_char(rx_char)
	);

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rx_sync1_r <= 1'b1;
			rx_sync2_r <= 1'b1;
			pin_out_r <= 1'b1;
		end
		else
		begin
			rx_sync1_r <= serial_in;
			rx_sync2_r <= rx_sync1_r;
			pin_out_r <= tx_line_r | maint_r;
		end
	end

	assign serial_out = pin_out_r;

	// ------------------------------------------------------------
	// Receiver flags
	// ------------------------------------------------------------
	// A character loaded while the read is in setup was not in the read data
	wire rx_clear = rx_buf_access && !rx_load_in_setup_r;
	wire rx_avail_nxt = rx_valid | (rx_avail_r & !rx_clear);
	wire overrun_nxt = (rx_valid & rx_avail_r & !rx_clear) | (overrun_r & !rx_clear);

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rx_avail_r <= 1'b0;
			overrun_r <= 1'b0;
			rx_data_r <= 8'h00;
			framing_r <= 1'b0;
			parity_flag_r <= 1'b0;
			rx_load_in_setup_r <= 1'b0;
		end
		else
		begin
			rx_avail_r <= rx_avail_nxt;
			overrun_r <= overrun_nxt;
			rx_load_in_setup_r <= setup && rx_valid;
			if (rx_valid)
			begin
				rx_data_r <= rx_char.data;
				framing_r <= rx_char.framing_bad;
				parity_flag_r <= rx_char.parity_bad;
			end
		end
	end

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rx_ie_r <= console_serial_pkg::RX_IE_RESET;
			tx_ie_r <= console_serial_pkg::TX_IE_RESET;
			maint_r <= console_serial_pkg::MAINT_RESET;
			irq_mask_r <= console_serial_pkg::IRQ_MASK_RESET;
			cfg_r.bit_cycles <= DEFAULT_CYCLES_16;
			cfg_r.parity_en <= console_serial_pkg::PARITY_EN_RESET;
			cfg_r.parity_odd <= console_serial_pkg::PARITY_ODD_RESET;
		end
		else
		begin
			if (wr_lane0 && sel_rx_cs)
				rx_ie_r <= pwdata[console_serial_pkg::RX_CS_IE_BIT];
			if (wr_lane0 && sel_tx_cs)
			begin
				tx_ie_r <= pwdata[console_serial_pkg::TX_CS_IE_BIT];
				maint_r <= pwdata[console_serial_pkg::TX_CS_MAINT_BIT];
			end
			if (wr_lane0 && sel_irq_mask)
				irq_mask_r <= pwdata[2:0];
			if (wr_lane0 && sel_cfg)
				cfg_r.bit_cycles[7:0] <= pwdata[7:0];
			if (wr_lane1 && sel_cfg)
				cfg_r.bit_cycles[15:8] <= pwdata[15:8];
			if (wr_lane2 && sel_cfg)
			begin
				cfg_r.parity_en <= pwdata[console_serial_pkg::CFG_PARITY_EN_BIT];
				cfg_r.parity_odd <= pwdata[console_serial_pkg::CFG_PARITY_ODD_BIT];
			end
		end
	end

	// ------------------------------------------------------------
	// Transmitter
	// ------------------------------------------------------------
	tx_state_t tx_state_r;
	logic tx_hold_full_r;
	logic [7:0] tx_shift_r;
	logic [15:0] tx_count_r;
	logic [2:0] tx_bit_r;
	logic tx_parity_r;

	wire tx_write = wr_lane0 && sel_tx_buf && tx_ready_r;
	wire tx_tick = (tx_count_r == 16'h0000);
	wire [15:0] tx_reload = line_cfg.bit_cycles - 16'h0001;
	wire tx_take = (tx_state_r == TX_IDLE) && tx_hold_full_r;

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			tx_ready_r <= console_serial_pkg::TX_READY_RESET;
			tx_hold_full_r <= 1'b0;
			tx_hold_r <= 8'h00;
		end
		else
		begin
			if (tx_write)
			begin
				tx_hold_r <= pwdata[7:0];
				tx_hold_full_r <= 1'b1;
				tx_ready_r <= 1'b0;
			end
			else if (tx_take)
			begin
				tx_hold_full_r <= 1'b0;
				tx_ready_r <= 1'b1;
			end
		end
	end

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			tx_state_r <= TX_IDLE;
			tx_shift_r <= 8'h00;
			tx_count_r <= 16'h0000;
			tx_bit_r <= 3'h0;
			tx_parity_r <= 1'b0;
			tx_line_r <= 1'b1;
		end
		else
		begin
			if (!tx_tick)
				tx_count_r <= tx_count_r - 16'h0001;
			case (tx_state_r)
				TX_IDLE:
					if (tx_take)
					begin
						tx_shift_r <= tx_hold_r;
						tx_parity_r <= line_cfg.parity_odd;
						tx_line_r <= 1'b0;
						tx_count_r <= tx_reload;
						tx_state_r <= TX_START;
					end
				TX_START:
					if (tx_tick)
					begin
						tx_line_r <= tx_shift_r[0];
						tx_parity_r <= tx_parity_r ^ tx_shift_r[0];
						tx_shift_r <= {1'b0, tx_shift_r[7:1]};
						tx_bit_r <= 3'h0;
						tx_count_r <= tx_reload;
						tx_state_r <= TX_DATA;
					end
				TX_DATA:
					if (tx_tick)
					begin
						tx_count_r <= tx_reload;
						tx_bit_r <= tx_bit_r + 3'h1;
						if (tx_bit_r == 3'h7)
						begin
							tx_line_r <= line_cfg.parity_en ? tx_parity_r : 1'b1;
							tx_state_r <= line_cfg.parity_en ? TX_PARITY : TX_STOP;
						end
						else
						begin
							tx_line_r <= tx_shift_r[0];
							tx_parity_r <= tx_parity_r ^ tx_shift_r[0];
							tx_shift_r <= {1'b0, tx_shift_r[7:1]};
						end
					end
				TX_PARITY:
					if (tx_tick)
					begin
						tx_line_r <= 1'b1;
						tx_count_r <= tx_reload;
						tx_state_r <= TX_STOP;
					end
				TX_STOP:
					if (tx_tick)
						tx_state_r <= TX_IDLE;
				default:
					tx_state_r <= TX_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Interrupt status, mask and output
	// ------------------------------------------------------------
	wire rx_req = rx_avail_r & rx_ie_r;
	wire tx_req = tx_ready_r & tx_ie_r;
	wire err_any = overrun_r | framing_r | parity_flag_r;
	wire [2:0] irq_events = {err_any & !err_prev_r, tx_req & !tx_req_prev_r,
		rx_req & !rx_req_prev_r};
	wire [2:0] irq_clear = irq_status_read ? irq_snap_r : 3'h0;
	wire [2:0] irq_status_nxt = (irq_status_r & ~irq_clear) | irq_events;

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			irq_status_r <= console_serial_pkg::IRQ_STATUS_RESET;
			rx_req_prev_r <= 1'b0;
			tx_req_prev_r <= 1'b0;
			err_prev_r <= 1'b0;
			irq <= 1'b0;
		end
		else
		begin
			irq_status_r <= irq_status_nxt;
			rx_req_prev_r <= rx_req;
			tx_req_prev_r <= tx_req;
			err_prev_r <= err_any;
			irq <= |(irq_status_nxt & irq_mask_r);
		end
	end

	// ------------------------------------------------------------
	// Read data, captured in the setup cycle
	// ------------------------------------------------------------
	logic [31:0] read_word;

	always_comb
	begin
		read_word = 32'h0000_0000;
		if (sel_rx_cs)
		begin
			read_word[console_serial_pkg::RX_CS_AVAIL_BIT] = rx_avail_r;
			read_word[console_serial_pkg::RX_CS_IE_BIT] = rx_ie_r;
		end
		if (sel_rx_buf)
		begin
			read_word[console_serial_pkg::RX_BUF_ERROR_BIT] = err_any;
			read_word[console_serial_pkg::RX_BUF_OVERRUN_BIT] = overrun_r;
			read_word[console_serial_pkg::RX_BUF_FRAMING_BIT] = framing_r;
			read_word[console_serial_pkg::RX_BUF_PARITY_BIT] = parity_flag_r;
			read_word[7:0] = rx_data_r;
		end
		if (sel_tx_cs)
		begin
			read_word[console_serial_pkg::TX_CS_READY_BIT] = tx_ready_r;
			read_word[console_serial_pkg::TX_CS_IE_BIT] = tx_ie_r;
			read_word[console_serial_pkg::TX_CS_MAINT_BIT] = maint_r;
		end
		if (sel_irq_status)
			read_word[2:0] = irq_status_r;
		if (sel_irq_mask)
			read_word[2:0] = irq_mask_r;
		if (sel_cfg)
		begin
			read_word[15:0] = cfg_r.bit_cycles;
			read_word[console_serial_pkg::CFG_PARITY_EN_BIT] = cfg_r.parity_en;
			read_word[console_serial_pkg::CFG_PARITY_ODD_BIT] = cfg_r.parity_odd;
		end
	end

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			prdata_r <= 32'h0000_0000;
			irq_snap_r <= 3'h0;
		end
		else if (setup)
		begin
			prdata_r <= pwrite ? 32'h0000_0000 : read_word;
			irq_snap_r <= irq_status_r;
		end
	end

	assign prdata = prdata_r;
endmodule

/* console_terminal.sv */
// Console terminal model at the far end of the serial line
`timescale 1ns/1ps
module console_terminal
#(
	parameter int BIT_CYCLES = 24
)
(
	input wire logic clock,
	input wire logic line_from_dut,
	output logic line_to_dut
);
	logic [7:0] got_q[$];
	logic [7:0] shift;
	initial line_to_dut = 1'b1;
	// --------
	// Sender
	// --------
	task automatic bit_out(input logic b);
		line_to_dut <= b;
		repeat (BIT_CYCLES) @(posedge clock);
	endtask
	// Start, data LSB first, optional parity, stop, then one idle bit
	task automatic send(input logic [7:0] d, input logic par_en, input logic par,
		input logic stop);
		bit_out(1'b0);
		for (int i = 0; i < 8; i++)
			bit_out(d[i]);
		if (par_en)
			bit_out(par);
		bit_out(stop);
		bit_out(1'b1);
	endtask
	// --------
	// Receiver
	// --------
	always
	begin
		@(negedge line_from_dut);
		repeat (BIT_CYCLES / 2) @(posedge clock);
		if (line_from_dut === 1'b0)
		begin
			for (int i = 0; i < 8; i++)
			begin
				repeat (BIT_CYCLES) @(posedge clock);
				shift[i] = line_from_dut;
			end
			repeat (BIT_CYCLES) @(posedge clock);
			if (line_from_dut === 1'b1)
				got_q.push_back(shift);
		end
	end
endmodule

/* console_serial_monitor.sv */
// Port-level checker bound to the console serial line unit
`timescale 1ns/1ps
module console_serial_monitor
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic serial_in,
	input wire logic serial_out,
	input wire logic irq
);
	// --------
	// Decode
	// --------
	logic maint_r;
	wire logic rd_acc = psel && penable && !pwrite;
	wire logic rd_rx_cs = rd_acc && paddr == console_serial_pkg::ADDR_RX_CONTROL_STATUS;
	wire logic rd_tx_cs = rd_acc && paddr == console_serial_pkg::ADDR_TX_CONTROL_STATUS;
	wire logic rd_rx_buf = rd_acc && paddr == console_serial_pkg::ADDR_RX_DATA_BUFFER;
	wire logic rd_tx_buf = rd_acc && paddr == console_serial_pkg::ADDR_TX_DATA_BUFFER;
	wire logic wr_acc = psel && penable && pwrite && pstrb[0];
	wire logic mapped = (paddr[1:0] == 2'h0) && (paddr <= 8'h18);
	wire logic maint_wr = wr_acc && (paddr == console_serial_pkg::ADDR_TX_CONTROL_STATUS);
	wire logic maint_nxt = maint_wr ? pwdata[2] : maint_r;
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			maint_r <= 1'b0;
		else
			maint_r <= maint_nxt;
	end
	default clocking @(posedge clock);
	endclocking
	default disable iff (!reset_n);
	// --------
	// Checks
	// --------
	chk_unmapped_err: assert property (psel && penable |-> pslverr == !mapped)
		else $error("pslverr disagrees with address decode");
	chk_reset_idle: assert property ($rose(reset_n) |-> serial_out && !irq && !pslverr)
		else $error("outputs not idle after reset");
	chk_start_hold: assert property ($fell(serial_out) |-> !serial_out [*8])
		else $error("start bit too short");
	chk_txbuf_zero: assert property (rd_tx_buf
		|-> prdata == 32'h0000_0000) else $error("transmit buffer read not zero");
	chk_rxcs_unused: assert property (rd_rx_cs
		|-> (prdata & 32'hFFFF_FF3F) == 32'h0000_0000) else $error("rx status unused bits set");
	chk_txcs_unused: assert property (rd_tx_cs
		|-> (prdata & 32'hFFFF_FF3B) == 32'h0000_0000) else $error("tx status unused bits set");
	chk_rxbuf_error: assert property (rd_rx_buf
		|-> prdata[15] == (|prdata[14:12]) && (prdata & 32'hFFFF_0F00) == 32'h0000_0000)
		else $error("error summary bit wrong");
	chk_mask_quiet: assert property (wr_acc && paddr == console_serial_pkg::ADDR_IRQ_MASK
		&& pwdata[2:0] == 3'h0 |-> ##2 !irq) else $error("irq stays up with mask clear");
	chk_loop_pin: assert property (maint_r && $past(maint_r) |-> serial_out)
		else $error("pin not held high in maintenance");
	cov_rx_error: cover property (rd_rx_buf && prdata[15]);
	cov_irq_rise: cover property ($rose(irq));
	cov_unmapped: cover property (psel && penable && !mapped);
	cov_loop: cover property (maint_r && $past(maint_r));
endmodule
bind console_serial_line_unit console_serial_monitor i_console_serial_monitor
(
	.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .serial_in(serial_in), .serial_out(serial_out), .irq(irq)
);

/* tb.sv */
// Self-checking bench for the console serial line unit
`timescale 1ns/1ps
module tb;
	localparam int LOOP = 16;
	localparam int BITS = 24;
	localparam logic [7:0] A_RX_CS = console_serial_pkg::ADDR_RX_CONTROL_STATUS;
	localparam logic [7:0] A_RX_BUF = console_serial_pkg::ADDR_RX_DATA_BUFFER;
	localparam logic [7:0] A_TX_CS = console_serial_pkg::ADDR_TX_CONTROL_STATUS;
	localparam logic [7:0] A_TX_BUF = console_serial_pkg::ADDR_TX_DATA_BUFFER;
	localparam logic [7:0] A_IRQ_ST = console_serial_pkg::ADDR_IRQ_STATUS;
	localparam logic [7:0] A_IRQ_MSK = console_serial_pkg::ADDR_IRQ_MASK;
	localparam logic [7:0] A_CFG = console_serial_pkg::ADDR_LINE_CONFIG;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0] pstrb = 4'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic serial_in;
	logic serial_out;
	logic irq;
	logic err_seen;
	logic [31:0] rdv;
	time t0;
	time cyc;
	int errors = 0;
	int n_tests = 0;
	always #5 clock = ~clock;
	console_serial_line_unit #(.LOOP_BIT_CYCLES(LOOP), .DEFAULT_BIT_CYCLES(BITS))
		i_console_serial_line_unit
	(
		.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .serial_in(serial_in), .serial_out(serial_out), .irq(irq)
	);
	console_terminal #(.BIT_CYCLES(BITS)) i_console_terminal
	(
		.clock(clock), .line_from_dut(serial_out), .line_to_dut(serial_in)
	);
	// --------
	// Helpers
	// --------
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= 4'hF;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1) @(posedge clock);
		rdv = prdata;
		err_seen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		check(name, rdv, exp);
	endtask
	task automatic snd(input logic [7:0] d, input logic pe, input logic par, input logic stop);
		i_console_terminal.send(d, pe, par, stop);
	endtask
	task automatic do_reset();
		reset_n <= 1'b0;
		repeat (3) @(posedge clock);
		reset_n <= 1'b1;
	endtask
	task automatic summarize();
		if (errors == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// --------
	// Scenarios
	// --------
	task automatic t_reset_vals();
		rdc("rx_cs", A_RX_CS, 32'h0000_0000);
		apb(1'b0, A_RX_BUF, 32'h0000_0000);
		check("rx_buf", rdv & 32'hFFFF_FF00, 32'h0000_0000);
		rdc("tx_cs", A_TX_CS, 32'h0000_0080);
		rdc("tx_buf", A_TX_BUF, 32'h0000_0000);
		rdc("irq_st", A_IRQ_ST, 32'h0000_0000);
		rdc("unmapped", 8'h1C, 32'h0000_0000);
		check("slverr", {31'h0, err_seen}, 32'h0000_0001);
	endtask
	task automatic t_regs();
		apb(1'b1, A_RX_CS, 32'hFFFF_FFFF);
		rdc("rx_cs_rw", A_RX_CS, 32'h0000_0040);
		apb(1'b1, A_TX_CS, 32'hFFFF_FFFF);
		rdc("tx_cs_rw", A_TX_CS, 32'h0000_00C4);
		apb(1'b1, A_TX_CS, 32'h0000_0000);
		rdc("tx_cs_clr", A_TX_CS, 32'h0000_0080);
		apb(1'b1, A_IRQ_MSK, 32'hFFFF_FFFF);
		rdc("irq_msk", A_IRQ_MSK, 32'h0000_0007);
		check("irq_up", {31'h0, irq}, 32'h0000_0001);
		rdc("irq_st_tx", A_IRQ_ST, 32'h0000_0002);
		rdc("irq_st_clr", A_IRQ_ST, 32'h0000_0000);
		check("irq_down", {31'h0, irq}, 32'h0000_0000);
	endtask
	task automatic t_tx();
		apb(1'b1, A_CFG, {14'h0000, 2'h0, 16'(BITS)});
		apb(1'b1, A_TX_CS, 32'h0000_0040);
		apb(1'b1, A_TX_BUF, 32'h0000_01A5);
		repeat (2) @(posedge clock);
		apb(1'b1, A_TX_BUF, 32'h0000_005A);
		rdc("tx_busy", A_TX_CS, 32'h0000_0040);
		while (i_console_terminal.got_q.size() < 2) @(posedge clock);
		check("tx_char0", i_console_terminal.got_q.pop_front(), 32'h0000_00A5);
		check("tx_char1", i_console_terminal.got_q.pop_front(), 32'h0000_005A);
		rdc("tx_ready", A_TX_CS, 32'h0000_00C0);
		rdc("irq_st_tx2", A_IRQ_ST, 32'h0000_0002);
		apb(1'b1, A_TX_CS, 32'h0000_0000);
	endtask
	task automatic t_rx();
		snd(8'h3C, 1'b0, 1'b0, 1'b1);
		rdc("rx_done", A_RX_CS, 32'h0000_00C0);
		check("irq_rx", {31'h0, irq}, 32'h0000_0001);
		rdc("rx_data", A_RX_BUF, 32'h0000_003C);
		rdc("rx_done_clr", A_RX_CS, 32'h0000_0040);
		rdc("irq_st_rx", A_IRQ_ST, 32'h0000_0001);
	endtask
	task automatic t_rx_err();
		apb(1'b1, A_CFG, {14'h0000, 2'h1, 16'(BITS)});
		snd(8'h81, 1'b1, ~(^8'h81), 1'b1);
		rdc("par_err", A_RX_BUF, 32'h0000_9081);
		snd(8'h42, 1'b1, ^8'h42, 1'b0);
		rdc("frm_err", A_RX_BUF, 32'h0000_A042);
		snd(8'h17, 1'b1, ^8'h17, 1'b1);
		snd(8'h18, 1'b1, ^8'h18, 1'b1);
		apb(1'b0, A_RX_BUF, 32'h0000_0000);
		check("ovr_err", rdv & 32'hFFFF_FF00, 32'h0000_C000);
		snd(8'h99, 1'b1, ^8'h99, 1'b1);
		rdc("err_clr", A_RX_BUF, 32'h0000_0099);
		apb(1'b1, A_CFG, {14'h0000, 2'h3, 16'(BITS)});
		snd(8'h99, 1'b1, ~(^8'h99), 1'b1);
		rdc("odd_par", A_RX_BUF, 32'h0000_0099);
		rdc("irq_st_err", A_IRQ_ST, 32'h0000_0005);
	endtask
	task automatic t_loop();
		apb(1'b1, A_CFG, {14'h0000, 2'h3, 16'(BITS)});
		apb(1'b1, A_TX_CS, 32'h0000_0004);
		apb(1'b1, A_TX_BUF, 32'h0000_00C3);
		t0 = $time;
		apb(1'b0, A_RX_CS, 32'h0000_0000);
		while (rdv[7] !== 1'b1) apb(1'b0, A_RX_CS, 32'h0000_0000);
		cyc = ($time - t0) / 10;
		check("loop_rate", {31'h0, cyc >= 9 * LOOP && cyc <= 12 * LOOP}, 32'h0000_0001);
		rdc("loop_data", A_RX_BUF, 32'h0000_00C3);
		check("pin_quiet", i_console_terminal.got_q.size(), 32'h0000_0000);
		apb(1'b1, A_TX_CS, 32'h0000_0000);
	endtask
	task automatic t_init();
		apb(1'b1, A_TX_CS, 32'h0000_0040);
		snd(8'h11, 1'b0, 1'b0, 1'b1);
		snd(8'h12, 1'b0, 1'b0, 1'b1);
		apb(1'b1, A_TX_CS, 32'h0000_0044);
		apb(1'b1, A_IRQ_MSK, 32'h0000_0000);
		repeat (2) @(posedge clock);
		check("irq_masked", {31'h0, irq}, 32'h0000_0000);
		do_reset();
		rdc("init_rx_cs", A_RX_CS, 32'h0000_0000);
		apb(1'b0, A_RX_BUF, 32'h0000_0000);
		check("init_ovr", rdv & 32'h0000_F000, 32'h0000_0000);
		rdc("init_tx_cs", A_TX_CS, 32'h0000_0080);
	endtask
	initial
	begin
		do_reset();
		t_reset_vals();
		t_regs();
		t_tx();
		t_rx();
		t_rx_err();
		t_loop();
		t_init();
		summarize();
	end
	initial
	begin
		#200_000;
		errors++;
		summarize();
	end
endmodule
